// >>> hdl/iopc_pkg.sv
// constants shared by the pin port controller and its helpers
// assumes one core clock and a synchronous active-high reset
package iopc_pkg;
  localparam int NUM_GROUPS_DEF = 14;    // port groups 0..d
  localparam int PINS_PER_GROUP = 8;     // pin index 0..7
  localparam int GRP_W          = 4;
  localparam int NUM_FUNCS      = 4;     // peripheral functions per pin
  localparam int CHOICE_W       = 2;
  localparam int NUM_SRC        = 4;     // filter clock sources
  localparam int SRC_W          = 2;
  localparam int DIV_W          = 4;
  localparam int DIV_CNT_W      = 15;    // enough for ratio 2**15
  localparam int KEY_W          = 16;
  localparam int DBG_GROUP      = 13;    // debug-shared group d
  localparam int DBG_PINS       = 3;     // pins 0..2 of that group
  localparam int OUT_ONLY_PIN   = 2;     // no gpio input path on this pin
  localparam logic [KEY_W-1:0]    PROTECT_KEY   = 16'h0096;
  localparam logic [CHOICE_W-1:0] DBG_FUNC      = 2'h0;
  localparam logic [SRC_W-1:0]    SRC_RST       = 2'h0;
  localparam logic [DIV_W-1:0]    DIV_RST       = 4'h0;
  localparam logic                RUN_DBG_RST   = 1'b0;
  localparam logic [7:0]          ALL_PINS      = 8'hff;
  localparam int CHOICE_LO_BASE = 0;     // choice fields, pins 0..3
  localparam int CHOICE_HI_BASE = 4;     // choice fields, pins 4..7

  // per-group configuration field written by the core
  typedef enum logic [2:0] {
    FLD_IN_EN     = 3'h0,
    FLD_OUT_EN    = 3'h1,
    FLD_ROUTE     = 3'h2,
    FLD_PULL_EN   = 3'h3,
    FLD_PULL_UP   = 3'h4,
    FLD_DEB_EN    = 3'h5,
    FLD_CHOICE_LO = 3'h6,
    FLD_CHOICE_HI = 3'h7
  } iopc_field_e;
endpackage

// >>> hdl/iopc_fclk.sv
// filter clock tick generator: source pick, power-of-two divider, gating
// assumes each source tick is a one-cycle pulse in the core clock domain
module iopc_fclk
  import iopc_pkg::*;
#(
  parameter int CNT_W = iopc_pkg::DIV_CNT_W
)
(
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic [iopc_pkg::NUM_SRC-1:0]  src_tick,
  input  wire logic [iopc_pkg::NUM_SRC-1:0]  source_sleep_stop,
  input  wire logic [iopc_pkg::SRC_W-1:0]    filter_clock_source,
  input  wire logic [iopc_pkg::DIV_W-1:0]    filter_clock_divider,
  input  wire logic                          run_in_debug,
  input  wire logic                          sleep_mode,
  input  wire logic                          debug_mode,
  output logic                               filt_tick,
  output logic                               sleep_bypass,
  output logic                               debug_hold
);
  logic [CNT_W-1:0] div_cnt_r;
  logic [CNT_W-1:0] div_mask;
  logic             running;

  if (CNT_W < (1 << DIV_W) - 1)
  begin : g_chk
    $error("iopc_fclk: divider counter too narrow");
  end

  // source stops in sleep, or supply paused for debug
  assign sleep_bypass = sleep_mode & source_sleep_stop[filter_clock_source];
  assign debug_hold   = debug_mode & ~run_in_debug;
  assign running      = src_tick[filter_clock_source] & ~sleep_bypass
                        & ~debug_hold;
  assign div_mask     = ~({CNT_W{1'b1}} << filter_clock_divider);
  assign filt_tick    = running & ((div_cnt_r & div_mask) == div_mask);

  // divider count advances only on live source ticks
  always_ff @(posedge core_clk)
  begin
    if (rst)
      div_cnt_r <= '0;
    else if (running)
      div_cnt_r <= div_cnt_r + 1'b1;
  end
endmodule

// >>> hdl/iopc_debounce.sv
// two-sample debounce filter for a vector of pins
// assumes tick is a one-cycle pulse at the filter clock rate
module iopc_debounce
#(
  parameter int N = 8
)
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic [N-1:0] din,
  output logic      [N-1:0] dout
);
  logic [N-1:0] samp0_r;
  logic [N-1:0] samp1_r;
  logic [N-1:0] agree;

  if (N < 1)
  begin : g_chk
    $error("iopc_debounce: N must be positive");
  end

  assign agree = ~(samp0_r ^ samp1_r);

  // output follows only after two equal consecutive samples
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      samp0_r <= '0;
      samp1_r <= '0;
      dout    <= '0;
    end
    else if (tick)
    begin
      samp0_r <= din;
      samp1_r <= samp0_r;
      dout    <= (dout & ~agree) | (samp1_r & agree);
    end
  end
endmodule

// >>> hdl/iopc_top.sv
// pin port controller: per-pin routing, drive, pulls and debounce
// assumes core writes and pad inputs are synchronous to core_clk;
// peripheral function 0 of the debug-shared pins is the debug unit
// Notes on behaviour
// [R1] each pin picks gpio or one of four peripherals via two-bit choice
// [R2] pins addressed by group index and pin index 0..7
// [R3] reset: input, output, pulls off, pad hi-z, gpio function
// [R4] reset: debug-shared pins routed to debug signals
// [R5] third debug-shared pin is output only in gpio mode
// [R6] pull-up, pull-down or none selectable per pin
// [R7] cleared input enable blocks the pin's gpio input path
// [R8] debounce works only while the filter clock is supplied
// [R9] software unlocks with key 0x0096 before filter clock setup
// [R10] filter clock setup holds two-bit source and four-bit divider
// [R11] source stopping in sleep disables debounce during sleep
// [R12] software clears sleep-stop bit to keep filtering in sleep
// [R13] run-in-debug 0 suspends filter clock in debug, resumes after
// [R14] debug suspend stops filter, filtered inputs dead, config writable
// [R15] run-in-debug 1 keeps filter clock and debounce running
// [R16] software disables pin, clears select, then sets choice and select
// [R17] function select 0 is gpio, 1 is chosen peripheral
// [R18] software sets output enable and clears select for gpio output
// [R19] debounce rejects pulses narrower than one to two filter periods
// [R20] filter clock writes while protected are ignored
// [R21] gpio drive only with gpio mode and output enable set
module iopc_top
#(
  parameter int NUM_GROUPS = iopc_pkg::NUM_GROUPS_DEF
)
(
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // per-group configuration writes
  input  wire logic                          cfg_wr,
  input  wire logic [iopc_pkg::GRP_W-1:0]    cfg_group,
  input  wire iopc_pkg::iopc_field_e         cfg_field,
  input  wire logic [7:0]                    cfg_data,
  // protection key and filter clock setup
  input  wire logic                          protect_key_wr,
  input  wire logic [iopc_pkg::KEY_W-1:0]    protect_key_field,
  input  wire logic                          clk_cfg_wr,
  input  wire logic [iopc_pkg::SRC_W-1:0]    clk_src_wdata,
  input  wire logic [iopc_pkg::DIV_W-1:0]    clk_div_wdata,
  input  wire logic                          clk_run_dbg_wdata,
  // clock generator and cpu state
  input  wire logic [iopc_pkg::NUM_SRC-1:0]  src_tick,
  input  wire logic [iopc_pkg::NUM_SRC-1:0]  source_sleep_stop,
  input  wire logic                          sleep_mode,
  input  wire logic                          debug_mode,
  // pads
  input  wire logic [NUM_GROUPS*8-1:0]       pad_in,
  output logic      [NUM_GROUPS*8-1:0]       pad_out,
  output logic      [NUM_GROUPS*8-1:0]       pad_oe,
  output logic      [NUM_GROUPS*8-1:0]       pad_pull_up,
  output logic      [NUM_GROUPS*8-1:0]       pad_pull_down,
  // gpio data
  input  wire logic [NUM_GROUPS*8-1:0]       gpio_out_data,
  output logic      [NUM_GROUPS*8-1:0]       gpio_in_data,
  // peripheral side, one row per function
  input  wire logic [3:0][NUM_GROUPS*8-1:0]  periph_out,
  input  wire logic [3:0][NUM_GROUPS*8-1:0]  periph_oe,
  output logic      [NUM_GROUPS*8-1:0]       periph_in,
  // filter clock setup status
  output logic      [iopc_pkg::SRC_W-1:0]    filter_clock_source,
  output logic      [iopc_pkg::DIV_W-1:0]    filter_clock_divider,
  output logic                               run_in_debug,
  output logic                               protect_open
);
  import iopc_pkg::*;

  localparam int N = NUM_GROUPS * PINS_PER_GROUP;

  if (NUM_GROUPS <= DBG_GROUP || NUM_GROUPS >= (1 << GRP_W))
  begin : g_chk
    $error("iopc_top: NUM_GROUPS must be 14 or 15");
  end

  // input-capable pins of a group; the output-only debug pin is masked
  function automatic logic [7:0] in_mask(input logic [GRP_W-1:0] g);
    in_mask = ALL_PINS;
    if (g == GRP_W'(DBG_GROUP))
      in_mask[OUT_ONLY_PIN] = 1'b0;
  endfunction

  // pins shared with the debug unit
  function automatic logic is_dbg(input int g, input int p);
    is_dbg = (g == DBG_GROUP) && (p < DBG_PINS);
  endfunction

  logic [NUM_GROUPS-1:0][7:0]               in_en_r;
  logic [NUM_GROUPS-1:0][7:0]               out_en_r;
  logic [NUM_GROUPS-1:0][7:0]               route_r;
  logic [NUM_GROUPS-1:0][7:0]               pull_en_r;
  logic [NUM_GROUPS-1:0][7:0]               pull_up_r;
  logic [NUM_GROUPS-1:0][7:0]               deb_en_r;
  logic [NUM_GROUPS-1:0][7:0][CHOICE_W-1:0] choice_r;
  logic [N-1:0]                             in_en_f;
  logic [N-1:0]                             out_en_f;
  logic [N-1:0]                             route_f;
  logic [N-1:0]                             pull_en_f;
  logic [N-1:0]                             pull_up_f;
  logic [N-1:0]                             deb_en_f;
  logic [N-1:0][CHOICE_W-1:0]               choice_f;
  logic [N-1:0]                             raw_in;
  logic [N-1:0]                             filt_in;
  logic [N-1:0]                             out_nxt;
  logic [N-1:0]                             oe_nxt;
  logic [N-1:0]                             pu_nxt;
  logic [N-1:0]                             pd_nxt;
  logic [N-1:0]                             gin_nxt;
  logic [N-1:0]                             pin_nxt;
  logic                                     cfg_hit;
  logic                                     filt_tick;
  logic                                     sleep_bypass;
  logic                                     debug_hold;

  assign in_en_f   = in_en_r;
  assign out_en_f  = out_en_r;
  assign route_f   = route_r;
  assign pull_en_f = pull_en_r;
  assign pull_up_f = pull_up_r;
  assign deb_en_f  = deb_en_r;
  assign choice_f  = choice_r;
  assign cfg_hit   = cfg_wr && (cfg_group < GRP_W'(NUM_GROUPS));

  // per-pin configuration, stays writable in every cpu state
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      for (int g = 0; g < NUM_GROUPS; g++)
      begin
        for (int p = 0; p < PINS_PER_GROUP; p++)
        begin
          // [R3] [R4] reset state
          in_en_r[g][p]   <= 1'b0;
          out_en_r[g][p]  <= 1'b0;
          pull_en_r[g][p] <= 1'b0;
          pull_up_r[g][p] <= 1'b0;
          deb_en_r[g][p]  <= 1'b0;
          route_r[g][p]   <= is_dbg(g, p);
          choice_r[g][p]  <= DBG_FUNC;
        end
      end
    end
    else if (cfg_hit)
    begin
      // [R2] [R14] group and pin addressing
      unique case (cfg_field)
        // [R5] output-only pin drops input enable
        FLD_IN_EN:   in_en_r[cfg_group]   <= cfg_data & in_mask(cfg_group);
        FLD_OUT_EN:  out_en_r[cfg_group]  <= cfg_data;
        FLD_ROUTE:   route_r[cfg_group]   <= cfg_data;
        // [R6] per-pin pull selection
        FLD_PULL_EN: pull_en_r[cfg_group] <= cfg_data;
        FLD_PULL_UP: pull_up_r[cfg_group] <= cfg_data;
        FLD_DEB_EN:  deb_en_r[cfg_group]  <= cfg_data;
        FLD_CHOICE_LO:
          for (int p = 0; p < 4; p++)
            choice_r[cfg_group][CHOICE_LO_BASE+p] <= cfg_data[2*p +: 2];
        FLD_CHOICE_HI:
          for (int p = 0; p < 4; p++)
            choice_r[cfg_group][CHOICE_HI_BASE+p] <= cfg_data[2*p +: 2];
      endcase
    end
  end

  // protection latch: key opens, any other value closes
  always_ff @(posedge core_clk)
  begin
    if (rst)
      protect_open <= 1'b0;
    else if (protect_key_wr)
      protect_open <= (protect_key_field == PROTECT_KEY);
  end

  // filter clock setup
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      filter_clock_source  <= SRC_RST;
      filter_clock_divider <= DIV_RST;
      run_in_debug         <= RUN_DBG_RST;
    end
    // [R10] [R20] protected setup
    else if (clk_cfg_wr && protect_open)
    begin
      filter_clock_source  <= clk_src_wdata;
      filter_clock_divider <= clk_div_wdata;
      run_in_debug         <= clk_run_dbg_wdata;
    end
  end

  // [R8] [R11] [R13] [R15] filter clock gating
  iopc_fclk #(
    .CNT_W (DIV_CNT_W)
  ) u_fclk (
    .core_clk             (core_clk),
    .rst                  (rst),
    .src_tick             (src_tick),
    .source_sleep_stop    (source_sleep_stop),
    .filter_clock_source  (filter_clock_source),
    .filter_clock_divider (filter_clock_divider),
    .run_in_debug         (run_in_debug),
    .sleep_mode           (sleep_mode),
    .debug_mode           (debug_mode),
    .filt_tick            (filt_tick),
    .sleep_bypass         (sleep_bypass),
    .debug_hold           (debug_hold)
  );

  // [R19] two-sample debounce
  iopc_debounce #(
    .N (N)
  ) u_deb (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (filt_tick),
    .din      (raw_in),
    .dout     (filt_in)
  );

  // per-pin pad and data path selection
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      // [R1] [R17] gpio or chosen peripheral
      out_nxt[i] = route_f[i] ? periph_out[choice_f[i]][i] : gpio_out_data[i];
      // [R21] gpio drive needs output enable
      oe_nxt[i]  = route_f[i] ? periph_oe[choice_f[i]][i] : out_en_f[i];
      // [R6] pulls only on undriven gpio pins
      pu_nxt[i]  = ~route_f[i] & pull_en_f[i] & pull_up_f[i] & ~out_en_f[i];
      pd_nxt[i]  = ~route_f[i] & pull_en_f[i] & ~pull_up_f[i] & ~out_en_f[i];
      // [R7] disabled input reads zero
      raw_in[i]  = pad_in[i] & in_en_f[i] & ~route_f[i];
      pin_nxt[i] = pad_in[i] & route_f[i];
      // [R11] [R14] bypass in sleep, dead while suspended for debug
      if (!deb_en_f[i])
        gin_nxt[i] = raw_in[i];
      else if (debug_hold)
        gin_nxt[i] = 1'b0;
      else if (sleep_bypass)
        gin_nxt[i] = raw_in[i];
      else
        gin_nxt[i] = filt_in[i];
    end
  end

  // registered pad and data outputs
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pad_out       <= '0;
      pad_oe        <= '0;
      pad_pull_up   <= '0;
      pad_pull_down <= '0;
      gpio_in_data  <= '0;
      periph_in     <= '0;
    end
    else
    begin
      pad_out       <= out_nxt;
      pad_oe        <= oe_nxt;
      pad_pull_up   <= pu_nxt;
      pad_pull_down <= pd_nxt;
      gpio_in_data  <= gin_nxt;
      periph_in     <= pin_nxt;
    end
  end

  localparam int PD2 = DBG_GROUP * PINS_PER_GROUP + OUT_ONLY_PIN;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // [R3] reset state on first cycle
  a_reset_quiet: assert property ($past(rst) |-> pad_pull_up == '0 && pad_pull_down == '0 && gpio_in_data == '0) else $error("pins not quiet after reset"); // [R3]
  // [R4] debug pins 1 and 2 routed after reset
  a_reset_debug: assert property ($past(rst) |-> route_f[PD2] && route_f[PD2-1] && !route_f[0]) else $error("debug pins not routed"); // [R4]
  // [R5] output-only pin
  a_pd2_no_in: assert property (!in_en_f[PD2] && !gpio_in_data[PD2]) else $error("output-only pin has input"); // [R5]
  // [R7] blocked input
  a_input_block: assert property (!in_en_f[0] && !deb_en_f[0] |=> !gpio_in_data[0]) else $error("disabled input leaked"); // [R7]
  // [R21] gpio drive
  a_gpio_drive: assert property (!route_f[0] |=> pad_oe[0] == $past(out_en_f[0])) else $error("gpio drive mismatch"); // [R21]
  // [R17] peripheral routing
  a_periph_route: assert property (route_f[1] |=> pad_out[1] == $past(periph_out[choice_f[1]][1])) else $error("peripheral output not routed"); // [R17]
  // [R20] protected setup ignored
  a_protect_key_field_ignore: assert property (clk_cfg_wr && !protect_open |=> $stable(filter_clock_source) && $stable(filter_clock_divider)) else $error("protected write taken"); // [R20]
  // [R10] unlocked setup taken
  a_protect_key_field_take: assert property (clk_cfg_wr && protect_open |=> filter_clock_divider == $past(clk_div_wdata)) else $error("unlocked write lost"); // [R10]
  // [R13] no tick while suspended
  a_debug_stop: assert property (debug_mode && !run_in_debug |-> !filt_tick) else $error("filter ticked in debug"); // [R13]
  // [R14] filtered input dead in debug suspend
  a_debug_dead: assert property (debug_hold && deb_en_f[0] |=> !gpio_in_data[0]) else $error("filtered input alive in debug"); // [R14]
  // [R11] sleep bypass passes raw input
  a_sleep_pass: assert property (sleep_bypass && !debug_hold && deb_en_f[0] |=> gpio_in_data[0] == $past(raw_in[0])) else $error("sleep bypass wrong"); // [R11]
  // [R6] pulls exclusive
  a_pull_mutex: assert property ((pad_pull_up & pad_pull_down) == '0) else $error("pull-up and pull-down together"); // [R6]

  c_gpio_out: cover property (!route_f[0] && out_en_f[0] ##1 pad_oe[0]);
  c_filter_tick: cover property (filt_tick && deb_en_f[0]);
  c_setup_taken: cover property (clk_cfg_wr && protect_open);
  c_sleep_bypass: cover property (sleep_bypass && deb_en_f[0]);
endmodule

// >>> sim/iopc_board.sv
// board and clock generator model around the pin port controller
// assumes one core clock; pad_in is the resolved level of each pin
module iopc_board
#(
  parameter int N = 112
)
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  input  wire logic [N-1:0] pad_pull_up,
  input  wire logic [N-1:0] pad_pull_down,
  input  wire logic [N-1:0] ext_drive,
  input  wire logic [N-1:0] ext_level,
  output logic      [3:0]   src_tick,
  output logic      [N-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_r = 8'h00;
  logic       float_r = 1'b0;  // an undriven pin wanders every cycle
  // clock generator count and floating level
  always_ff @(posedge core_clk)
  begin
    cnt_r   <= rst ? 8'h00 : cnt_r + 8'h01;
    float_r <= ~float_r;
  end
  // filter source supply
  // source s gives a one-cycle pulse every 2*(s+1) cycles
  always_comb
    for (int s = 0; s < 4; s++)
      src_tick[s] = (int'(cnt_r) % (2 * (s + 1))) == 0;
  // own drive first, then board driver, then resistor, else floating
  always_comb
    for (int i = 0; i < N; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_drive[i] ? ext_level[i] :
                  pad_pull_up[i] ? 1'b1 :
                  pad_pull_down[i] ? 1'b0 : float_r;
endmodule

// >>> sim/test_iopc_top.sv
// self-checking bench for the pin port controller
// assumes the board model drives pads and supplies the filter sources
module test_iopc_top;
  import iopc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = 112;
  localparam logic [N-1:0] DBG_M = N'(3'h7) << (DBG_GROUP * 8);
  typedef struct packed {
    iopc_field_e fld;
    logic [3:0]  grp;
    logic [7:0]  dat;
    logic [6:0]  pin;
    logic [3:0]  exp;  // oe, pull up, pull down, gpio input
  } iopc_row_s;
  logic core_clk = 1'b0;
  logic rst, cfg_wr, protect_key_wr, clk_cfg_wr, clk_run_dbg_wdata;
  logic sleep_mode, debug_mode, run_in_debug, protect_open;
  logic [3:0] cfg_group, src_tick, source_sleep_stop, clk_div_wdata;
  logic [3:0] filter_clock_divider;
  logic [1:0] clk_src_wdata, filter_clock_source;
  iopc_field_e cfg_field;
  logic [7:0] cfg_data;
  logic [15:0] protect_key_field;
  logic [N-1:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
  logic [N-1:0] gpio_out_data, gpio_in_data, periph_in;
  logic [N-1:0] ext_drive, ext_level;
  logic [3:0][N-1:0] periph_out, periph_oe;
  int miscompares = 0;
  int n_compared = 0;
  int p;
  iopc_row_s rows [14] = '{
    '{FLD_IN_EN, 4'h2, 8'h1a, 7'd17, 4'h1},
    '{FLD_IN_EN, 4'h2, 8'h00, 7'd17, 4'h0},
    '{FLD_PULL_EN, 4'h2, 8'h08, 7'd19, 4'h2},
    '{FLD_PULL_UP, 4'h2, 8'h08, 7'd19, 4'h4},
    '{FLD_OUT_EN, 4'h2, 8'h08, 7'd19, 4'h8},
    '{FLD_ROUTE, 4'h2, 8'h08, 7'd19, 4'h0},
    '{FLD_CHOICE_LO, 4'h2, 8'h40, 7'd19, 4'h8},
    '{FLD_CHOICE_LO, 4'h2, 8'h80, 7'd19, 4'h0},
    '{FLD_CHOICE_LO, 4'h2, 8'hc0, 7'd19, 4'h8},
    '{FLD_ROUTE, 4'h2, 8'h00, 7'd19, 4'h8},
    '{FLD_OUT_EN, 4'he, 8'hff, 7'd3, 4'h0},
    '{FLD_ROUTE, 4'hd, 8'h00, 7'd104, 4'h0},
    '{FLD_IN_EN, 4'hd, 8'h07, 7'd105, 4'h1},
    '{FLD_IN_EN, 4'hd, 8'h07, 7'd106, 4'h0}};

  iopc_top #(.NUM_GROUPS(14)) iopc_top_i (.*);
  iopc_board #(.N(N)) iopc_board_i (.*);

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // compare and count one result
  task automatic cmp(input logic [N-1:0] got, input logic [N-1:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one per-group field write
  task automatic cfg(input iopc_field_e f, input logic [3:0] g,
                     input logic [7:0] d);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_field <= f;
    cfg_group <= g;
    cfg_data <= d;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask

  // key write followed at once by a filter clock setup write
  task automatic clk_setup(input logic [15:0] k, input logic [1:0] s,
                           input logic [3:0] d, input logic r);
    @(posedge core_clk);
    protect_key_wr <= 1'b1;
    protect_key_field <= k;
    @(posedge core_clk);
    protect_key_wr <= 1'b0;
    clk_cfg_wr <= 1'b1;
    clk_src_wdata <= s;
    clk_div_wdata <= d;
    clk_run_dbg_wdata <= r;
    @(posedge core_clk);
    clk_cfg_wr <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  // wait for a gpio input level, or demand it holds, for lim cycles
  task automatic watch(input int i, input logic v, input int lim,
                       input bit stay);
    logic ok;
    ok = stay;
    repeat (lim)
    begin
      @(posedge core_clk);
      #1;
      if (stay)
        ok &= gpio_in_data[i] === v;
      else
        ok |= gpio_in_data[i] === v;
    end
    cmp(N'(ok), N'(1'b1), "gpio input watch");
  endtask

  function automatic logic [N-1:0] status();
    return N'({filter_clock_source, filter_clock_divider,
               run_in_debug, protect_open});
  endfunction

  // closing report
  task automatic results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    #100us;
    miscompares++;
    results();
  end

  // main sequence
  initial
  begin
    {rst, cfg_wr, protect_key_wr, clk_cfg_wr, clk_run_dbg_wdata} = 5'h10;
    {sleep_mode, debug_mode, source_sleep_stop} = 6'h00;
    cfg_group = 4'h0;
    cfg_field = FLD_IN_EN;
    cfg_data = 8'h00;
    protect_key_field = 16'h0000;
    {clk_src_wdata, clk_div_wdata} = 6'h00;
    {ext_drive, ext_level, gpio_out_data} = '1;
    periph_out = '0;
    periph_oe = '0;
    periph_oe[0] = N'(3'h5) << (DBG_GROUP * 8);
    periph_oe[1] = '1;
    periph_oe[3] = '1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    cmp(pad_oe & ~DBG_M, '0, "reset drive");
    cmp(pad_pull_up | pad_pull_down | gpio_in_data, '0, "reset pulls");
    cmp(pad_oe & DBG_M, periph_oe[0] & DBG_M, "debug drive");
    cmp(periph_in & DBG_M, N'(1'b1) << (DBG_GROUP * 8 + 1), "debug in");
    cmp(status(), '0, "clock setup reset");
    foreach (rows[k])
    begin
      cfg(rows[k].fld, rows[k].grp, rows[k].dat);
      @(posedge core_clk);
      #1;
      p = rows[k].pin;
      cmp(N'({pad_oe[p], pad_pull_up[p], pad_pull_down[p],
              gpio_in_data[p]}), N'(rows[k].exp), "pin row");
    end
    cmp(N'(pad_out[19]), N'(1'b1), "gpio out data");
    clk_setup(16'h0095, 2'h1, 4'h2, 1'b1);
    cmp(status(), '0, "locked setup");
    clk_setup(16'h0096, 2'h1, 4'h3, 1'b1);
    cmp(status(), N'(8'h4f), "open setup");
    clk_setup(16'h1234, 2'h2, 4'h0, 1'b0);
    cmp(status(), N'(8'h4e), "relocked setup");
    clk_setup(16'h0096, 2'h0, 4'h0, 1'b0);
    cfg(FLD_IN_EN, 4'h1, 8'h01);
    cfg(FLD_DEB_EN, 4'h1, 8'h01);
    watch(8, 1'b1, 20, 1'b0);
    @(posedge core_clk);
    ext_level[8] <= 1'b0;
    @(posedge core_clk);
    ext_level[8] <= 1'b1;
    watch(8, 1'b1, 20, 1'b1);
    debug_mode <= 1'b1;
    watch(8, 1'b0, 8, 1'b0);
    cfg(FLD_OUT_EN, 4'h1, 8'h02);
    @(posedge core_clk);
    #1;
    cmp(N'(pad_oe[9]), N'(1'b1), "write in debug");
    debug_mode <= 1'b0;
    watch(8, 1'b1, 20, 1'b0);
    clk_setup(16'h0096, 2'h0, 4'h0, 1'b1);
    debug_mode <= 1'b1;
    @(posedge core_clk);
    ext_level[8] <= 1'b0;
    @(posedge core_clk);
    ext_level[8] <= 1'b1;
    watch(8, 1'b1, 20, 1'b1);
    debug_mode <= 1'b0;
    source_sleep_stop <= 4'h1;
    sleep_mode <= 1'b1;
    @(posedge core_clk);
    ext_level[8] <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    cmp(N'(gpio_in_data[8]), '0, "sleep bypass");
    // sleep-stop cleared keeps the filter alive in sleep
    source_sleep_stop <= 4'h0;
    repeat (12) @(posedge core_clk);
    ext_level[8] <= 1'b1;
    @(posedge core_clk);
    ext_level[8] <= 1'b0;
    watch(8, 1'b0, 20, 1'b1);
    results();
  end
endmodule
